//--- rtl/ipmr_pkg.sv
/*
 * Constants of the per-source pending, mask and command register set:
 * register byte addresses, source bit layout, reset values, bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
 */
package ipmr_pkg;

    localparam int          ADDR_W            = 12;

    // Register byte addresses
    localparam logic [11:0] ADDR_PENDING      = 12'h10c;
    localparam logic [11:0] ADDR_MASK         = 12'h110;
    localparam logic [11:0] ADDR_CORE_LINES   = 12'h114;
    localparam logic [11:0] ADDR_ENABLE_CMD   = 12'h120;
    localparam logic [11:0] ADDR_DISABLE_CMD  = 12'h124;
    localparam logic [11:0] ADDR_CLEAR_CMD    = 12'h128;
    localparam logic [11:0] ADDR_SET_CMD      = 12'h12c;
    localparam logic [11:0] ADDR_EVENT_STATUS = 12'h140;
    localparam logic [11:0] ADDR_EVENT_MASK   = 12'h144;

    // Source bit positions in every per-source register
    localparam int          BIT_FAST          = 0;
    localparam int          BIT_SOFT          = 1;
    localparam int          BIT_SERIAL_A      = 2;
    localparam int          BIT_SERIAL_B      = 3;
    localparam int          BIT_TIMER_A       = 4;
    localparam int          BIT_TIMER_B       = 5;
    localparam int          BIT_TIMER_C       = 6;
    localparam int          BIT_WATCHDOG      = 7;
    localparam int          BIT_PARALLEL      = 8;
    localparam int          BIT_EXT_A         = 16;
    localparam int          BIT_EXT_B         = 17;
    localparam int          BIT_EXT_C         = 18;
    localparam logic [31:0] USED_SOURCES      = 32'h0007_01ff;
    localparam logic [31:0] NORMAL_SOURCES    = 32'h0007_01fe;

    // Core line status and event bits
    localparam int          LINE_FAST         = 0;
    localparam int          LINE_NORMAL       = 1;

    localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // Word address with the byte offset dropped
    function automatic logic [11:0] word_of(input logic [11:0] addr);
        word_of = {addr[11:2], 2'h0};
    endfunction

    // True for every decoded register address
    function automatic logic addr_mapped(input logic [11:0] addr);
        logic [11:0] w;
        w = word_of(addr);
        addr_mapped = (w == ADDR_PENDING) || (w == ADDR_MASK) || (w == ADDR_CORE_LINES)
                   || (w == ADDR_ENABLE_CMD) || (w == ADDR_DISABLE_CMD)
                   || (w == ADDR_CLEAR_CMD) || (w == ADDR_SET_CMD)
                   || (w == ADDR_EVENT_STATUS) || (w == ADDR_EVENT_MASK);
    endfunction

    // Written data with unstrobed byte lanes forced to zero
    function automatic logic [31:0] strobe_bits(input logic [31:0] data,
                                                input logic [3:0]  strb);
        strobe_bits = data & {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage

//--- rtl/ipmr_regs.sv
/*
 * Pending, mask and command registers for twelve interrupt sources, with
 * the fast and normal request lines to the core and an AXI4-Lite slave.
 * Assumes peripheral sources share aclk; the fast and external request pins
 * are asynchronous and are synchronised here.
 */
// The AXI4-Lite register port was left to the implementer.
// Behaviour
// - Pending register reads pending sources, resets zero
// - Mask register reads enabled sources, resets disabled
// - Fixed bit layout of the twelve sources
// - Core status shows fast and normal lines
// - Enable command sets mask bits written one
// - Disable command clears mask bits written one
// - Clear command clears pending bits written one
// - Set command forces pending bits written one
`timescale 1ns/100ps

module ipmr_regs
    import ipmr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fast_pin,
    input  wire logic        serial_port_a_source,
    input  wire logic        serial_port_b_source,
    input  wire logic        timer_a_source,
    input  wire logic        timer_b_source,
    input  wire logic        timer_c_source,
    input  wire logic        watchdog_source,
    input  wire logic        parallel_port_source,
    input  wire logic        external_request_a,
    input  wire logic        external_request_b,
    input  wire logic        external_request_c,
    output logic             fast_request_line,
    output logic             normal_request_line,
    output logic [31:0]      active_sources,
    output logic             irq
);

    typedef struct packed {
        logic        fast_meta;
        logic        fast_sync;
        logic [2:0]  ext_meta;
        logic [2:0]  ext_sync;
        logic [31:0] src_prev;
        logic [31:0] pending;
        logic [31:0] mask;
        logic [31:0] active;
        logic        fast_line;
        logic        normal_line;
        logic [1:0]  ev_status;
        logic [1:0]  ev_mask;
        logic        irq;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_bits;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ipmr_state_type;

    ipmr_state_type s;
    ipmr_state_type next_s;

    logic [31:0] src_now;
    logic [31:0] rise;
    logic        wr_fire;
    logic [11:0] wr_addr;
    logic [31:0] wr_bits;

    // Source levels in register layout; software bit has no hardware source
    always_comb begin
        src_now                = RESET_WORD;
        src_now[BIT_FAST]      = s.fast_sync;
        src_now[BIT_SERIAL_A]  = serial_port_a_source;
        src_now[BIT_SERIAL_B]  = serial_port_b_source;
        src_now[BIT_TIMER_A]   = timer_a_source;
        src_now[BIT_TIMER_B]   = timer_b_source;
        src_now[BIT_TIMER_C]   = timer_c_source;
        src_now[BIT_WATCHDOG]  = watchdog_source;
        src_now[BIT_PARALLEL]  = parallel_port_source;
        src_now[BIT_EXT_A]     = s.ext_sync[0];
        src_now[BIT_EXT_B]     = s.ext_sync[1];
        src_now[BIT_EXT_C]     = s.ext_sync[2];
    end

    // Rising edges latch pending; a held-high source does not re-pend after a clear
    assign rise    = src_now & ~s.src_prev & USED_SOURCES;

    // A write completes in the cycle both halves are present, held or arriving
    assign wr_fire = (s.aw_held | (awvalid & s.awready))
                   & (s.w_held | (wvalid & s.wready)) & ~s.bvalid;
    assign wr_addr = s.aw_held ? word_of(s.aw_addr) : word_of(awaddr);
    assign wr_bits = s.w_held ? s.w_bits : strobe_bits(wdata, wstrb);

    // Next state of the whole block
    always_comb begin
        logic [31:0] en_bits;
        logic [31:0] dis_bits;
        logic [31:0] clr_bits;
        logic [31:0] set_bits;
        logic [1:0]  ev_clr;
        logic [1:0]  ev_rise;
        logic [11:0] rd_addr;
        en_bits  = RESET_WORD;
        dis_bits = RESET_WORD;
        clr_bits = RESET_WORD;
        set_bits = RESET_WORD;
        ev_clr   = 2'h0;
        ev_rise  = 2'h0;
        rd_addr  = word_of(araddr);
        next_s   = s;

        // Two flops on the fast and external request pins before anything looks at them
        next_s.fast_meta = fast_pin;
        next_s.fast_sync = s.fast_meta;
        next_s.ext_meta  = {external_request_c, external_request_b, external_request_a};
        next_s.ext_sync  = s.ext_meta;
        next_s.src_prev  = src_now;

        // Write address and data taken in either order
        if (s.awready && awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (s.wready && wvalid) begin
            next_s.w_held = 1'b1;
            next_s.w_bits = strobe_bits(wdata, wstrb);
        end
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (wr_addr)
                ADDR_ENABLE_CMD:   en_bits = wr_bits;
                ADDR_DISABLE_CMD:  dis_bits = wr_bits;
                ADDR_CLEAR_CMD:    clr_bits = wr_bits;
                ADDR_SET_CMD:      set_bits = wr_bits;
                ADDR_EVENT_STATUS: ev_clr = wr_bits[1:0];
                ADDR_EVENT_MASK:   next_s.ev_mask = wr_bits[1:0];
                default:           en_bits = RESET_WORD;
            endcase
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // Ready flags held low while a response waits, so only one write is open
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;

        // Mask: enable sets, disable clears, zeros leave bits alone
        next_s.mask = ((s.mask | en_bits) & ~dis_bits) & USED_SOURCES;

        // Pending: a hardware edge or a set beats a clear in the same cycle
        next_s.pending = ((s.pending & ~clr_bits) | set_bits | rise) & USED_SOURCES;

        // Only enabled pending sources reach priority logic and the core lines
        next_s.active      = s.pending & s.mask;
        next_s.fast_line   = s.pending[BIT_FAST] & s.mask[BIT_FAST];
        next_s.normal_line = |(s.pending & s.mask & NORMAL_SOURCES);

        // Line rises are sticky events; write one clears, a new rise wins
        ev_rise[LINE_FAST]   = next_s.fast_line & ~s.fast_line;
        ev_rise[LINE_NORMAL] = next_s.normal_line & ~s.normal_line;
        next_s.ev_status     = (s.ev_status & ~ev_clr) | ev_rise;
        next_s.irq           = |(next_s.ev_status & next_s.ev_mask);

        // Read channel: one read open at a time, answered the next cycle
        if (s.arready && arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = addr_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (rd_addr)
                ADDR_PENDING:      next_s.rdata = s.pending;
                ADDR_MASK:         next_s.rdata = s.mask;
                ADDR_CORE_LINES:   next_s.rdata = {30'h0, s.normal_line, s.fast_line};
                ADDR_EVENT_STATUS: next_s.rdata = {30'h0, s.ev_status};
                ADDR_EVENT_MASK:   next_s.rdata = {30'h0, s.ev_mask};
                default:           next_s.rdata = RESET_WORD;
            endcase
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;
    end

    // State register; all zero in reset, ready flags rise the cycle after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awready             = s.awready;
    assign wready              = s.wready;
    assign bvalid              = s.bvalid;
    assign bresp               = s.bresp;
    assign arready             = s.arready;
    assign rvalid              = s.rvalid;
    assign rdata               = s.rdata;
    assign rresp               = s.rresp;
    assign fast_request_line   = s.fast_line;
    assign normal_request_line = s.normal_line;
    assign active_sources      = s.active;
    assign irq                 = s.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cmd_write(logic [11:0] a);
        wr_fire && (wr_addr == a);
    endsequence

    sequence s_core_read;
        s.arready && arvalid && (word_of(araddr) == ADDR_CORE_LINES);
    endsequence

    property p_pending_reset;
        $rose(aresetn) |-> (s.pending == RESET_WORD) && !fast_request_line;
    endproperty
    a_pending_reset: assert property (p_pending_reset)
        else $error("pending not zero after reset");

    property p_mask_reset;
        $rose(aresetn) |-> (s.mask == RESET_WORD) ##1 (active_sources == RESET_WORD);
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("sources enabled after reset");

    property p_unused_zero;
        ((s.pending | s.mask | active_sources) & ~USED_SOURCES) == RESET_WORD;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit position set");

    property p_core_read;
        s_core_read |=> rvalid && (rdata[LINE_FAST] == $past(fast_request_line))
                        && (rdata[LINE_NORMAL] == $past(normal_request_line));
    endproperty
    a_core_read: assert property (p_core_read)
        else $error("core status read differs from lines");

    property p_enable;
        s_cmd_write(ADDR_ENABLE_CMD) |=> ((s.mask & $past(wr_bits) & USED_SOURCES)
            == ($past(wr_bits) & USED_SOURCES)) && (($past(s.mask) & ~s.mask) == RESET_WORD);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable command mask update wrong");

    property p_disable;
        s_cmd_write(ADDR_DISABLE_CMD) |=> ((s.mask & $past(wr_bits)) == RESET_WORD)
            && ((s.mask & ~$past(s.mask)) == RESET_WORD);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable command mask update wrong");

    property p_clear;
        s_cmd_write(ADDR_CLEAR_CMD) |=> ((s.pending & $past(wr_bits) & ~$past(rise))
            == RESET_WORD) ##1 ((fast_request_line == 1'b0) || !$past(wr_bits[BIT_FAST], 2)
            || $past(rise[BIT_FAST], 2));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear command left pending bit");

    property p_set;
        s_cmd_write(ADDR_SET_CMD) |=> ((s.pending & $past(wr_bits) & USED_SOURCES)
            == ($past(wr_bits) & USED_SOURCES));
    endproperty
    a_set: assert property (p_set)
        else $error("set command did not force pending");

    property p_present;
        ##1 (active_sources == $past(s.pending & s.mask))
            && (fast_request_line == $past(s.pending[BIT_FAST] & s.mask[BIT_FAST]));
    endproperty
    a_present: assert property (p_present)
        else $error("presented source not pending and enabled");

endmodule

//--- tb/ipmr_core_model.sv
/*
 * Behavioural model of the processor core request inputs.
 * Assumes active-high request lines that share aclk with the block.
 */
`timescale 1ns/100ps

module ipmr_core_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic fast_request_line,
    input  wire logic normal_request_line,
    output logic      fast_seen,
    output logic      normal_seen
);
    // The core samples its request inputs once per clock, so it lags a cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_seen   <= 1'b0;
            normal_seen <= 1'b0;
        end else begin
            fast_seen   <= fast_request_line;
            normal_seen <= normal_request_line;
        end
    end
endmodule

//--- tb/ipmr_regs_tb_top.sv
/*
 * Self-checking bench of the pending, mask and command registers.
 * Assumes one 40 MHz clock; bus answers are checked by a scoreboard queue.
 */
`timescale 1ns/100ps

module ipmr_regs_tb_top;
    import ipmr_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, fast_seen, normal_seen;
    logic        fast_request_line, normal_request_line;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, src, exp_pend, exp_mask, seed, r, active_sources, exp_ln;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q[$];
    int          mismatches, compares, cycles;

    ipmr_regs i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .fast_pin(src[BIT_FAST]),
        .serial_port_a_source(src[BIT_SERIAL_A]), .serial_port_b_source(src[BIT_SERIAL_B]),
        .timer_a_source(src[BIT_TIMER_A]), .timer_b_source(src[BIT_TIMER_B]),
        .timer_c_source(src[BIT_TIMER_C]), .watchdog_source(src[BIT_WATCHDOG]),
        .parallel_port_source(src[BIT_PARALLEL]), .external_request_a(src[BIT_EXT_A]),
        .external_request_b(src[BIT_EXT_B]), .external_request_c(src[BIT_EXT_C]),
        .fast_request_line(fast_request_line), .normal_request_line(normal_request_line),
        .active_sources(active_sources), .irq(irq)
    );

    ipmr_core_model i_core (
        .aclk(aclk), .aresetn(aresetn), .fast_request_line(fast_request_line),
        .normal_request_line(normal_request_line), .fast_seen(fast_seen),
        .normal_seen(normal_seen)
    );

    // Free-running bus clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Empty queue yields unknown so a stray answer never matches
    function automatic logic [33:0] pop();
        if (exp_q.size() == 0)
            return 'x;
        return exp_q.pop_front();
    endfunction

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected core status word from the bench's own pending and mask copies
    function automatic logic [31:0] lines();
        logic [31:0] act;
        act = exp_pend & exp_mask;
        return {30'h0, |(act & NORMAL_SOURCES), act[BIT_FAST]};
    endfunction

    // Scoreboard: each bus answer meets the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready)
            cmp({rresp, rdata}, pop());
        if (bvalid && bready)
            cmp({bresp, 32'h0}, pop());
    end

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end

    // Address and data go out together; each is dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        exp_q.push_back({rs, 32'h0});
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready && !ad) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (wready && !wd) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] rs);
        exp_q.push_back({rs, e});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
        {awaddr, araddr, wdata, src, exp_pend, exp_mask} = '0;
        wstrb = 4'hf;
        seed = 32'h0357d93e;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_PENDING, 32'h0, RESP_OKAY);
        rd(ADDR_MASK, 32'h0, RESP_OKAY);
        rd(ADDR_CORE_LINES, 32'h0, RESP_OKAY);
        rd(ADDR_SET_CMD, 32'h0, RESP_OKAY);
        rd(12'h200, 32'h0, RESP_SLVERR);
        wr(12'h200, 32'hffffffff, RESP_SLVERR);
        wr(ADDR_PENDING, 32'hffffffff, RESP_OKAY);
        rd(ADDR_PENDING, 32'h0, RESP_OKAY);
        // Random command words; unused bits must stay zero
        for (int i = 0; i < 8; i++) begin
            r = xs();
            wr(ADDR_SET_CMD, r, RESP_OKAY);
            exp_pend = exp_pend | (r & USED_SOURCES);
            rd(ADDR_PENDING, exp_pend, RESP_OKAY);
            r = xs();
            wr(ADDR_CLEAR_CMD, r, RESP_OKAY);
            exp_pend = exp_pend & ~r;
            rd(ADDR_PENDING, exp_pend, RESP_OKAY);
            r = xs();
            wr(ADDR_ENABLE_CMD, r, RESP_OKAY);
            exp_mask = exp_mask | (r & USED_SOURCES);
            rd(ADDR_MASK, exp_mask, RESP_OKAY);
            r = xs();
            wr(ADDR_DISABLE_CMD, r, RESP_OKAY);
            exp_mask = exp_mask & ~r;
            rd(ADDR_MASK, exp_mask, RESP_OKAY);
            rd(ADDR_CORE_LINES, lines(), RESP_OKAY);
            cmp(active_sources, exp_pend & exp_mask);
            exp_ln = lines();
            cmp({fast_seen, normal_seen}, {exp_ln[LINE_FAST], exp_ln[LINE_NORMAL]});
        end
        // Mid-run reset with every source pending and enabled must empty both again
        wr(ADDR_SET_CMD, USED_SOURCES, RESP_OKAY);
        wr(ADDR_ENABLE_CMD, USED_SOURCES, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        exp_pend = RESET_WORD;
        exp_mask = RESET_WORD;
        rd(ADDR_PENDING, 32'h0, RESP_OKAY);
        rd(ADDR_MASK, 32'h0, RESP_OKAY);
        rd(ADDR_CORE_LINES, 32'h0, RESP_OKAY);
        wr(ADDR_CLEAR_CMD, 32'hffffffff, RESP_OKAY);
        wr(ADDR_ENABLE_CMD, 32'hffffffff, RESP_OKAY);
        exp_mask = USED_SOURCES;
        // Each source input pulses once and must land in its own bit
        for (int b = 0; b < 19; b++) begin
            if (USED_SOURCES[b] && b != BIT_SOFT) begin
                src <= 32'h1 << b;
                repeat (6) @(posedge aclk);
                src <= 32'h0;
                rd(ADDR_PENDING, 32'h1 << b, RESP_OKAY);
                wr(ADDR_CLEAR_CMD, 32'h1 << b, RESP_OKAY);
                rd(ADDR_PENDING, 32'h0, RESP_OKAY);
            end
        end
        // Line-rise events: sticky, masked, cleared by writing one
        wr(ADDR_EVENT_STATUS, 32'h3, RESP_OKAY);
        rd(ADDR_EVENT_STATUS, 32'h0, RESP_OKAY);
        wr(ADDR_EVENT_MASK, 32'h1, RESP_OKAY);
        rd(ADDR_EVENT_MASK, 32'h1, RESP_OKAY);
        wr(ADDR_SET_CMD, 32'h1 << BIT_TIMER_A, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp(irq, 1'b0);
        rd(ADDR_EVENT_STATUS, 32'h2, RESP_OKAY);
        wr(ADDR_SET_CMD, 32'h1, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp(irq, 1'b1);
        rd(ADDR_CORE_LINES, 32'h3, RESP_OKAY);
        wr(ADDR_EVENT_STATUS, 32'h1, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp(irq, 1'b0);
        wr(ADDR_EVENT_MASK, 32'h3, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp(irq, 1'b1);
        wr(ADDR_EVENT_STATUS, 32'h2, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp(irq, 1'b0);
        report_and_stop;
    end
endmodule
